//--- core/perf_count_pkg.sv
// Types shared by the event counter control block
package perf_count_pkg;

   typedef struct packed {
      logic [5:0]  event_class;
      logic [15:0] event_mask;
      logic [3:0]  tag_value;
      logic        tag_enable;
      logic        thread0_kernel_count;
      logic        thread0_user_count;
      logic        thread1_kernel_count;
      logic        thread1_user_count;
   } event_selection_type;

   typedef enum logic [1:0] {
      ACT_NONE   = 2'h0,
      ACT_SINGLE = 2'h1,
      ACT_ANY    = 2'h3,
      ACT_BOTH   = 2'h2
   } activity_type;

   typedef struct packed {
      logic         overflow_sticky_flag;
      logic         cascade;
      logic [1:0]   reserved;
      logic         overflow_irq_thread1;
      logic         overflow_irq_thread0;
      logic         force_overflow_each_increment;
      logic         edge_detect;
      logic [3:0]   threshold;
      logic         complement;
      logic         compare;
      activity_type activity;
      logic [2:0]   select;
      logic         enable;
   } counter_config_type;

   typedef struct packed {
      logic [1:0] priv_level;
      logic       halted;
      logic       startup_interrupt_wait;
   } thread_status_type;

   typedef struct packed {
      logic        wr;
      logic        rd;
      logic [11:0] addr;
      logic [63:0] wdata;
      logic        thread;
   } msr_req_type;

endpackage : perf_count_pkg

//--- core/perf_count_regs.svh
// Register offsets, field positions and constants of the event counter control block
// Functional notes
// - Selection bit 0 counts thread 1 events at privilege 1 to 3.
// - Selection bit 1 counts thread 1 events at privilege 0.
// - Selection bit 2 counts thread 0 events at privilege 1 to 3.
// - Selection bit 3 counts thread 0 events at privilege 0.
// - Selection bit 4 turns micro-operation tagging on or off.
// - Selection bits 5..8 give the tag value for retirement counting.
// - Selection bits 9..24 mask events within the chosen class.
// - Selection bits 25..30 choose the event class.
// - Config bit 12 enables counting; cleared by reset.
// - Config bits 13..15 pick the selection register feeding the counter.
// - Config bits 16..17 gate counting by how many threads are active.
// - A halted or startup-waiting thread counts as inactive.
// - Config bit 18 enables threshold filtering; other filter bits need it.
// - Bit 19 set: count at or below threshold gives one; clear: above.
// - Threshold comes from config bits 20..23, used only when filtering.
// - Bit 24 with filtering counts only rising edges of the comparison.
// - Bit 25 forces an overflow on every increment.
// - Overflow interrupts thread 0 (bit 26) or 1 (bit 27) on next count.
// - Bit 30 starts a counter once its partner overflows.
// - Bit 31 is set on overflow and held until software clears it.
// - Precise enable bit 25 is own thread, bit 26 the other thread.
// - Precise sampling only on three classes, counter 0 and counter 1.
`ifndef PERF_COUNT_REGS_SVH
`define PERF_COUNT_REGS_SVH

// ----------------------------------------------------------------------
// Offsets
// ----------------------------------------------------------------------
`define OFS_CFG0      12'h370
`define OFS_CFG1      12'h371
`define OFS_SEL_BASE  12'h3a0
`define OFS_PRECISE   12'h3f1
`define OFS_CNT0      12'h30c
`define OFS_CNT1      12'h30d

// ----------------------------------------------------------------------
// Fields and values
// ----------------------------------------------------------------------
`define CFG_LSB       12
`define CFG_MSB       31
`define SEL_MSB       30
`define PSE_OWN_BIT   25
`define PSE_OTH_BIT   26
`define PRIV_KERNEL   2'h0
`define REG_RST_VAL   '0

`endif

//--- core/thread_priv_qualify.sv
// Thread and privilege qualification of incoming event counts
`timescale 1ns/100ps
`default_nettype none
`include "perf_count_regs.svh"

module thread_priv_qualify (
   input  wire perf_count_pkg::event_selection_type     sel_in,
   input  wire perf_count_pkg::thread_status_type [1:0] thread_in,
   input  wire logic [1:0][3:0]                         count_in,
   output logic [4:0]                                   qual_out
);

   logic [1:0] pass;

   always_comb begin
      pass[0] = (thread_in[0].priv_level == `PRIV_KERNEL) ?
                sel_in.thread0_kernel_count :
                sel_in.thread0_user_count;
      pass[1] = (thread_in[1].priv_level == `PRIV_KERNEL) ?
                sel_in.thread1_kernel_count :
                sel_in.thread1_user_count;
      qual_out = (pass[0] ? {1'b0, count_in[0]} : 5'h00) +
                 (pass[1] ? {1'b0, count_in[1]} : 5'h00);
   end

endmodule : thread_priv_qualify
`default_nettype wire

//--- core/threshold_filter.sv
// Threshold, complement and edge filter of a qualified event count
`timescale 1ns/100ps
`default_nettype none

module threshold_filter (
   input  wire perf_count_pkg::counter_config_type cfg_in,
   input  wire logic [4:0]                         count_in,
   input  wire logic                               prev_in,
   output logic [4:0]                              inc_out,
   output logic                                    cmp_out
);

   always_comb begin
      cmp_out = cfg_in.complement ?
                (count_in <= {1'b0, cfg_in.threshold}) :
                (count_in >  {1'b0, cfg_in.threshold});
      if (!cfg_in.compare) begin
         inc_out = count_in;
      end else if (cfg_in.edge_detect) begin
         inc_out = {4'h0, cmp_out & ~prev_in};
      end else begin
         inc_out = {4'h0, cmp_out};
      end
   end

endmodule : threshold_filter
`default_nettype wire

//--- core/two_thread_event_counter_control.sv
// Two-thread event counter qualification, configuration and overflow logic
`timescale 1ns/100ps
`default_nettype none
`include "perf_count_regs.svh"

module two_thread_event_counter_control #(
   parameter int          NSEL        = 2,
   parameter int          CNT_W       = 40,
   parameter logic [5:0]  RET_CLASS_A = 6'h01,
   parameter logic [5:0]  RET_CLASS_B = 6'h02,
   parameter logic [5:0]  RET_CLASS_C = 6'h03
) (
   input  wire logic                                      core_clk_in,
   input  wire logic                                      reset_in,
   input  wire perf_count_pkg::msr_req_type               msr_req_in,
   output logic                                           msr_ack_out,
   output logic [63:0]                                    msr_rdata_out,
   input  wire perf_count_pkg::thread_status_type [1:0]   thread_in,
   input  wire logic [NSEL-1:0][1:0][3:0]                 event_count_in,
   output perf_count_pkg::event_selection_type [NSEL-1:0] sel_cfg_out,
   output logic [NSEL-1:0][3:0]                           uop_tag_out,
   output logic [1:0]                                     perf_monitor_interrupt_out,
   output logic [1:0]                                     precise_sample_capture_out,
   output logic [1:0]                                     overflow_sticky_flag_out
);

   // ----------------------------------------------------------------------
   // State
   // ----------------------------------------------------------------------
   typedef struct packed {
      perf_count_pkg::counter_config_type [1:0]       cfg;
      perf_count_pkg::event_selection_type [NSEL-1:0] sel;
      logic [1:0]                                     precise_en;
      logic [1:0][CNT_W-1:0]                          cnt;
      logic [1:0]                                     cmp_prev;
      logic [1:0]                                     irq_pend;
      logic [1:0]                                     casc_armed;
      logic [1:0]                                     irq;
      logic [1:0]                                     precise;
      logic                                           ack;
      logic [63:0]                                    rdata;
   } state_type;

   state_type st_r;
   state_type st_nxt;

   perf_count_pkg::event_selection_type cur_sel [2];
   logic [1:0][3:0] sel_cnt  [2];
   logic [4:0]      qual_sum [2];
   logic [4:0]      filt_inc [2];
   logic [1:0]      cmp_now;
   logic [1:0]      act_ok;
   logic [1:0]      run_ok;
   logic [4:0]      inc_eff  [2];
   logic [CNT_W:0]  sum_ext  [2];
   logic [1:0]      overflow_ev;
   logic [1:0]      cfg_hit;
   logic [1:0]      cnt_hit;
   logic [NSEL-1:0] sel_hit;
   logic            precise_hit;
   logic [1:0]      active;
   logic [1:0]      n_active;

   function automatic logic is_ret_class(input logic [5:0] cls);
      is_ret_class = (cls == RET_CLASS_A) || (cls == RET_CLASS_B) ||
                     (cls == RET_CLASS_C);
   endfunction : is_ret_class

   // ----------------------------------------------------------------------
   // Thread activity
   // ----------------------------------------------------------------------
   // Both stalled states count as inactive so idle threads never gate in
   always_comb begin
      active[0] = ~thread_in[0].halted & ~thread_in[0].startup_interrupt_wait;
      active[1] = ~thread_in[1].halted & ~thread_in[1].startup_interrupt_wait;
      n_active  = {1'b0, active[0]} + {1'b0, active[1]};
   end

   // ----------------------------------------------------------------------
   // Per-counter event path
   // ----------------------------------------------------------------------
   for (genvar gi = 0; gi < 2; gi++) begin : g_ctr
      logic sel_valid;

      // A select value beyond the implemented registers feeds no events
      assign sel_valid = 32'(st_r.cfg[gi].select) < NSEL;
      assign cur_sel[gi] = sel_valid ? st_r.sel[st_r.cfg[gi].select] : '0;
      assign sel_cnt[gi] = sel_valid ? event_count_in[st_r.cfg[gi].select] : '0;

      thread_priv_qualify u_qual (
         .sel_in   (cur_sel[gi]),
         .thread_in(thread_in),
         .count_in (sel_cnt[gi]),
         .qual_out (qual_sum[gi])
      );

      threshold_filter u_filt (
         .cfg_in  (st_r.cfg[gi]),
         .count_in(qual_sum[gi]),
         .prev_in (st_r.cmp_prev[gi]),
         .inc_out (filt_inc[gi]),
         .cmp_out (cmp_now[gi])
      );

      always_comb begin
         case (st_r.cfg[gi].activity)
            perf_count_pkg::ACT_NONE:   act_ok[gi] = (n_active == 2'h0);
            perf_count_pkg::ACT_SINGLE: act_ok[gi] = (n_active == 2'h1);
            perf_count_pkg::ACT_BOTH:   act_ok[gi] = (n_active == 2'h2);
            perf_count_pkg::ACT_ANY:    act_ok[gi] = (n_active != 2'h0);
            default:                    act_ok[gi] = 1'b0;
         endcase
      end

      // A cascaded counter stays idle until its partner has wrapped
      assign run_ok[gi] = st_r.cfg[gi].enable & act_ok[gi] &
                          (~st_r.cfg[gi].cascade | st_r.casc_armed[gi]);
      assign inc_eff[gi] = run_ok[gi] ? filt_inc[gi] : 5'h00;
      assign sum_ext[gi] = {1'b0, st_r.cnt[gi]} +
                           (CNT_W + 1)'(inc_eff[gi]);
      assign overflow_ev[gi] = (inc_eff[gi] != 5'h00) &
                               (sum_ext[gi][CNT_W] |
                                st_r.cfg[gi].force_overflow_each_increment);
   end

   for (genvar gs = 0; gs < NSEL; gs++) begin : g_sel
      assign sel_hit[gs] = msr_req_in.addr == (`OFS_SEL_BASE + 12'(gs));
      // Tags reach the core only while tagging is on
      assign uop_tag_out[gs] = st_r.sel[gs].tag_enable ?
                               st_r.sel[gs].tag_value : 4'h0;
   end

   // ----------------------------------------------------------------------
   // Register decode
   // ----------------------------------------------------------------------
   assign cfg_hit[0]  = msr_req_in.addr == `OFS_CFG0;
   assign cfg_hit[1]  = msr_req_in.addr == `OFS_CFG1;
   assign cnt_hit[0]  = msr_req_in.addr == `OFS_CNT0;
   assign cnt_hit[1]  = msr_req_in.addr == `OFS_CNT1;
   assign precise_hit = msr_req_in.addr == `OFS_PRECISE;

   // ----------------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------------
   always_comb begin
      st_nxt         = st_r;
      st_nxt.ack     = msr_req_in.wr | msr_req_in.rd;
      st_nxt.irq     = 2'h0;
      st_nxt.precise = 2'h0;

      for (int i = 0; i < 2; i++) begin
         st_nxt.cnt[i]      = sum_ext[i][CNT_W-1:0];
         st_nxt.cmp_prev[i] = cmp_now[i];
         if (!st_r.cfg[i].cascade) begin
            st_nxt.casc_armed[i] = 1'b0;
         end else if (overflow_ev[1-i]) begin
            st_nxt.casc_armed[i] = 1'b1;
         end
         // The interrupt waits for the first count after the wrap
         if (st_r.irq_pend[i] && inc_eff[i] != 5'h00) begin
            st_nxt.irq_pend[i] = 1'b0;
            st_nxt.irq = st_nxt.irq |
                         {st_r.cfg[i].overflow_irq_thread1,
                          st_r.cfg[i].overflow_irq_thread0};
         end
         if (overflow_ev[i]) begin
            st_nxt.irq_pend[i] = 1'b1;
         end
         // Counter i serves thread i only
         st_nxt.precise[i] = overflow_ev[i] & st_r.precise_en[i] &
                             is_ret_class(cur_sel[i].event_class);
      end

      if (msr_req_in.wr) begin
         for (int i = 0; i < 2; i++) begin
            if (cfg_hit[i]) begin
               st_nxt.cfg[i] = msr_req_in.wdata[`CFG_MSB:`CFG_LSB];
               st_nxt.cfg[i].reserved = 2'h0;
            end
            if (cnt_hit[i]) begin
               st_nxt.cnt[i] = msr_req_in.wdata[CNT_W-1:0];
            end
         end
         for (int n = 0; n < NSEL; n++) begin
            if (sel_hit[n]) begin
               st_nxt.sel[n] = msr_req_in.wdata[`SEL_MSB:0];
            end
         end
         if (precise_hit) begin
            // Stored per absolute thread, seen relative to the caller
            st_nxt.precise_en[msr_req_in.thread]  =
               msr_req_in.wdata[`PSE_OWN_BIT];
            st_nxt.precise_en[~msr_req_in.thread] =
               msr_req_in.wdata[`PSE_OTH_BIT];
         end
      end

      // A wrap in the same cycle as a software clear keeps the flag set
      for (int i = 0; i < 2; i++) begin
         if (overflow_ev[i]) begin
            st_nxt.cfg[i].overflow_sticky_flag = 1'b1;
         end
      end

      if (msr_req_in.rd) begin
         st_nxt.rdata = 64'h0;
         for (int i = 0; i < 2; i++) begin
            if (cfg_hit[i]) begin
               st_nxt.rdata[`CFG_MSB:`CFG_LSB] = st_r.cfg[i];
            end
            if (cnt_hit[i]) begin
               st_nxt.rdata[CNT_W-1:0] = st_r.cnt[i];
            end
         end
         for (int n = 0; n < NSEL; n++) begin
            if (sel_hit[n]) begin
               st_nxt.rdata[`SEL_MSB:0] = st_r.sel[n];
            end
         end
         if (precise_hit) begin
            st_nxt.rdata[`PSE_OWN_BIT] = st_r.precise_en[msr_req_in.thread];
            st_nxt.rdata[`PSE_OTH_BIT] = st_r.precise_en[~msr_req_in.thread];
         end
      end
   end

   always_ff @(posedge core_clk_in) begin
      if (reset_in) begin
         st_r <= `REG_RST_VAL;
      end else begin
         st_r <= st_nxt;
      end
   end

   // ----------------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------------
   assign msr_ack_out                = st_r.ack;
   assign msr_rdata_out              = st_r.rdata;
   assign sel_cfg_out                = st_r.sel;
   assign perf_monitor_interrupt_out = st_r.irq;
   assign precise_sample_capture_out = st_r.precise;
   assign overflow_sticky_flag_out   = {st_r.cfg[1].overflow_sticky_flag,
                                        st_r.cfg[0].overflow_sticky_flag};

   // ----------------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------------
   default clocking cb @(posedge core_clk_in);
   endclocking
   default disable iff (reset_in);

   logic cfg0_wr;
   assign cfg0_wr = msr_req_in.wr & cfg_hit[0];

   reset_clear_a: assert property ($past(reset_in) |-> !st_r.cfg[0].enable)
      else $error("counter enable not cleared by reset");

   disabled_idle_a: assert property (!st_r.cfg[0].enable |-> inc_eff[0] == 5'h00)
      else $error("disabled counter incremented");

   none_active_a: assert property (
      (st_r.cfg[0].activity == perf_count_pkg::ACT_NONE && active != 2'h0)
      |-> inc_eff[0] == 5'h00)
      else $error("count while threads active in none mode");

   halted_gate_a: assert property (
      (st_r.cfg[0].activity == perf_count_pkg::ACT_BOTH && thread_in[0].halted)
      |-> inc_eff[0] == 5'h00)
      else $error("halted thread treated as active");

   edge_once_a: assert property (
      (st_r.cfg[0].compare && st_r.cfg[0].edge_detect && st_r.cmp_prev[0])
      |-> filt_inc[0] == 5'h00)
      else $error("edge filter counted a held comparison");

   force_wrap_a: assert property (
      (st_r.cfg[0].force_overflow_each_increment && inc_eff[0] != 5'h00)
      |=> st_r.cfg[0].overflow_sticky_flag && st_r.irq_pend[0])
      else $error("forced overflow missed");

   sticky_hold_a: assert property (
      (st_r.cfg[0].overflow_sticky_flag && !cfg0_wr)
      |=> st_r.cfg[0].overflow_sticky_flag [*1] ##0 $stable(st_r.cfg[0].overflow_sticky_flag))
      else $error("overflow flag dropped without software");

   irq_next_a: assert property (
      (st_r.irq_pend[0] && inc_eff[0] != 5'h00 && st_r.cfg[0].overflow_irq_thread0)
      |=> perf_monitor_interrupt_out[0] ##1 !perf_monitor_interrupt_out[0] || st_r.irq[0])
      else $error("interrupt not raised on next count");

   irq_cause_a: assert property (
      perf_monitor_interrupt_out[1] |-> $past(st_r.irq_pend[0] | st_r.irq_pend[1]))
      else $error("interrupt without pending overflow");

   precise_own_a: assert property (
      precise_sample_capture_out[0] |-> $past(st_r.precise_en[0]) && $past(overflow_ev[0]))
      else $error("precise sample without enable and overflow");

   // A write to OFS_CNT0 reloads the count, so all write cycles are left out
   count_step_a: assert property (
      !msr_req_in.wr |=>
      st_r.cnt[0] == $past(st_r.cnt[0]) + CNT_W'($past(inc_eff[0])))
      else $error("count step wrong");

   count1_idle_a: assert property (
      !st_r.cfg[1].enable
      |-> inc_eff[1] == 5'h00)
      else $error("disabled counter 1 counted");

   filter_off_a: assert property (
      !st_r.cfg[0].compare
      |-> filt_inc[0] == qual_sum[0])
      else $error("unfiltered count altered");

   filter_pulse_a: assert property (
      st_r.cfg[0].compare
      |-> filt_inc[0] <= 5'h01)
      else $error("filter gave more than one");

   // The partner's wrap arms this counter one cycle later
   cascade_idle_a: assert property (
      (st_r.cfg[1].cascade && !st_r.casc_armed[1])
      |-> inc_eff[1] == 5'h00)
      else $error("cascaded counter ran early");

   tag_gate_a: assert property (
      !st_r.sel[0].tag_enable
      |-> uop_tag_out[0] == 4'h0)
      else $error("tag shown while tagging off");

   irq_route_a: assert property (
      perf_monitor_interrupt_out[0] |->
      $past(st_r.cfg[0].overflow_irq_thread0 | st_r.cfg[1].overflow_irq_thread0))
      else $error("thread 0 interrupt not steered");

   precise_class_a: assert property (
      precise_sample_capture_out[0]
      |-> $past(is_ret_class(cur_sel[0].event_class)))
      else $error("precise sample on wrong class");

endmodule : two_thread_event_counter_control
`default_nettype wire

//--- test/event_source_model.sv
// Behavioural event source standing in for the core's per-thread event wires
`timescale 1ns/100ps
`default_nettype none

module event_source_model (
   input  wire logic            core_clk_in,
   input  wire logic            start_in,
   input  wire logic [7:0]      len_in,
   input  wire logic [3:0]      t0_cnt_in,
   input  wire logic [3:0]      t1_cnt_in,
   output logic [1:0][1:0][3:0] event_count_out
);
   int   left = 0;
   logic go;

   initial event_count_out = '0;

   // Counts change just after the edge, so every burst covers whole cycles
   always @(posedge core_clk_in) begin
      go = start_in;
      #1;
      if (go) begin
         left = len_in;
      end
      if (left > 0) begin
         event_count_out = {8'h00, t1_cnt_in, t0_cnt_in};
         left--;
      end else begin
         event_count_out = '0;
      end
   end
endmodule : event_source_model
`default_nettype wire

//--- test/two_thread_event_counter_control_tb.sv
// Self-checking bench for the two-thread event counter control block
`timescale 1ns/100ps
`default_nettype none
`include "perf_count_regs.svh"

module two_thread_event_counter_control_tb;
   typedef struct packed {
      logic [3:0] sel;
      logic [8:0] cfg;
      logic [7:0] st;
      logic [7:0] exp;
   } row_type;

   logic                                    core_clk_in = 1'b0;
   logic                                    reset_in    = 1'b1;
   perf_count_pkg::msr_req_type             req         = '0;
   perf_count_pkg::thread_status_type [1:0] thr         = '0;
   perf_count_pkg::event_selection_type [1:0] sel_cfg;
   logic                                    ack;
   logic [63:0]                             rdata;
   logic [63:0]                             rd;
   logic [1:0][1:0][3:0]                    ev;
   logic [1:0][3:0]                         tag;
   logic [1:0]                              irq;
   logic [1:0]                              pcap;
   logic [1:0]                              flag;
   logic [1:0]                              irq_seen    = '0;
   logic [1:0]                              pcap_seen   = '0;
   logic                                    start       = 1'b0;
   logic [7:0]                              len         = 8'h04;
   int                                      err_count   = 0;
   int                                      num_checks  = 0;
   // Thread 0 brings 3 events a cycle, thread 1 brings 5; totals over 4 cycles
   // Complement rows also count the five idle cycles around a burst
   row_type rows [16] = '{
      '{4'h1, 9'h003, 8'hcc, 8'h14},
      '{4'h2, 9'h003, 8'h0c, 8'h14},
      '{4'h2, 9'h003, 8'hcc, 8'h00},
      '{4'h4, 9'h003, 8'h04, 8'h0c},
      '{4'h8, 9'h003, 8'h00, 8'h0c},
      '{4'hf, 9'h003, 8'h0c, 8'h20},
      '{4'hf, 9'h000, 8'h00, 8'h00},
      '{4'hf, 9'h000, 8'h22, 8'h20},
      '{4'hf, 9'h001, 8'h20, 8'h20},
      '{4'hf, 9'h002, 8'h10, 8'h00},
      '{4'hf, 9'h002, 8'h00, 8'h20},
      '{4'hf, 9'h067, 8'h00, 8'h04},
      '{4'hf, 9'h06f, 8'h00, 8'h05},
      '{4'hf, 9'h08f, 8'h00, 8'h09},
      '{4'hf, 9'h167, 8'h00, 8'h01},
      '{4'hf, 9'h0f3, 8'h00, 8'h20}};

   always #2 core_clk_in = ~core_clk_in;

   always @(posedge core_clk_in) begin
      irq_seen  <= irq_seen | irq;
      pcap_seen <= pcap_seen | pcap;
   end

   two_thread_event_counter_control u_dut (
      .core_clk_in                (core_clk_in),
      .reset_in                   (reset_in),
      .msr_req_in                 (req),
      .msr_ack_out                (ack),
      .msr_rdata_out              (rdata),
      .thread_in                  (thr),
      .event_count_in             (ev),
      .sel_cfg_out                (sel_cfg),
      .uop_tag_out                (tag),
      .perf_monitor_interrupt_out (irq),
      .precise_sample_capture_out (pcap),
      .overflow_sticky_flag_out   (flag)
   );

   event_source_model u_src (
      .core_clk_in     (core_clk_in),
      .start_in        (start),
      .len_in          (len),
      .t0_cnt_in       (4'h3),
      .t1_cnt_in       (4'h5),
      .event_count_out (ev)
   );

   task automatic give_verdict();
      $display("checks %0d errors %0d", num_checks, err_count);
      if (err_count == 0 && num_checks > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask : give_verdict

   task automatic chk(input logic [63:0] got, input logic [63:0] exp, input string what);
      num_checks++;
      if (got !== exp) begin
         err_count++;
         $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask : chk

   // One access; the ack is due just after the edge that takes the request
   task automatic msr(input logic w, input logic [11:0] a, input logic [63:0] d, input logic t);
      @(posedge core_clk_in);
      #1;
      req = '{wr: w, rd: !w, addr: a, wdata: d, thread: t};
      @(posedge core_clk_in);
      #1;
      req = '0;
      chk({63'h0, ack}, 64'h1, "ack");
      rd = rdata;
   endtask : msr

   task automatic burst(input logic [7:0] n);
      len = n;
      @(posedge core_clk_in);
      #1;
      start = 1'b1;
      @(posedge core_clk_in);
      #1;
      start = 1'b0;
      repeat (n + 2) @(posedge core_clk_in);
      #1;
   endtask : burst

   initial begin
      repeat (10) @(posedge core_clk_in);
      #1;
      reset_in = 1'b0;
      chk({62'h0, flag}, 64'h0, "flag after reset");
      msr(1'b0, `OFS_CFG0, '0, 1'b0);
      chk(rd, 64'h0, "config reset");
      for (int i = 0; i < 16; i++) begin
         msr(1'b1, `OFS_CFG0, {39'h0, rows[i].cfg, 4'h1, 12'h000}, 1'b0);
         msr(1'b1, `OFS_SEL_BASE, {60'h0, rows[i].sel}, 1'b0);
         msr(1'b1, `OFS_CNT0, '0, 1'b0);
         thr = rows[i].st;
         burst(8'h04);
         msr(1'b0, `OFS_CNT0, '0, 1'b0);
         chk(rd, {56'h0, rows[i].exp}, "row count");
      end
      // Source picked by the select field, not by position
      msr(1'b1, `OFS_CNT0, '0, 1'b0);
      msr(1'b1, `OFS_CFG0, 64'h0003_3000, 1'b0);
      burst(8'h04);
      msr(1'b0, `OFS_CNT0, '0, 1'b0);
      chk(rd, 64'h0, "select one");
      // Genuine wrap of the 40-bit count
      msr(1'b1, `OFS_CNT0, 64'h00ff_ffff_ffff, 1'b0);
      msr(1'b1, `OFS_CFG0, 64'h0003_1000, 1'b0);
      burst(8'h01);
      chk({62'h0, flag}, 64'h1, "wrap flag");
      msr(1'b0, `OFS_CFG0, '0, 1'b0);
      chk(rd, 64'h8003_1000, "flag readback");
      msr(1'b1, `OFS_CFG0, 64'h0003_1000, 1'b0);
      chk({62'h0, flag}, 64'h0, "software clear");
      // Forced overflow, steering and precise capture on a retirement class
      msr(1'b1, `OFS_PRECISE, 64'h0200_0000, 1'b0);
      msr(1'b0, `OFS_PRECISE, '0, 1'b1);
      chk(rd, 64'h0400_0000, "other thread view");
      msr(1'b1, `OFS_SEL_BASE, 64'h0200_000f, 1'b0);
      msr(1'b1, `OFS_CNT0, '0, 1'b0);
      irq_seen = '0;
      pcap_seen = '0;
      msr(1'b1, `OFS_CFG0, 64'h0603_1000, 1'b0);
      burst(8'h02);
      chk({60'h0, irq_seen, flag}, 64'h5, "pmi to thread 0");
      chk({62'h0, pcap_seen}, 64'h1, "precise capture");
      irq_seen = '0;
      msr(1'b1, `OFS_CFG0, 64'h0a03_1000, 1'b0);
      burst(8'h02);
      chk({62'h0, irq_seen}, 64'h2, "pmi to thread 1");
      // Counter 1 starts on the cycle after counter 0 wraps
      msr(1'b1, `OFS_CNT0, 64'h00ff_ffff_ffff, 1'b0);
      msr(1'b1, `OFS_CFG1, 64'h4003_1000, 1'b0);
      msr(1'b1, `OFS_CFG0, 64'h0003_1000, 1'b0);
      burst(8'h02);
      msr(1'b0, `OFS_CNT1, '0, 1'b0);
      chk(rd, 64'h8, "cascade count");
      msr(1'b1, `OFS_CFG1, '0, 1'b0);
      msr(1'b1, `OFS_CFG0, '0, 1'b0);
      // Readable fields and ignored bits
      msr(1'b1, `OFS_CFG1, '1, 1'b0);
      msr(1'b0, `OFS_CFG1, '0, 1'b0);
      chk(rd, 64'hcfff_f000, "config bits");
      msr(1'b1, `OFS_CFG1, '0, 1'b0);
      msr(1'b1, `OFS_SEL_BASE + 12'h001, '1, 1'b0);
      msr(1'b0, `OFS_SEL_BASE + 12'h001, '0, 1'b0);
      chk(rd, 64'h7fff_ffff, "selection bits");
      chk({33'h0, sel_cfg[1]}, 64'h7fff_ffff, "selection out");
      chk({60'h0, tag[1]}, 64'hf, "tag on");
      msr(1'b1, `OFS_SEL_BASE + 12'h001, 64'h01e0, 1'b0);
      chk({60'h0, tag[1]}, 64'h0, "tag off");
      msr(1'b0, 12'h123, '0, 1'b0);
      chk(rd, 64'h0, "unmapped read");
      // Reset in mid-run clears the enable
      msr(1'b1, `OFS_CFG0, 64'h0003_1000, 1'b0);
      reset_in = 1'b1;
      repeat (2) @(posedge core_clk_in);
      #1;
      reset_in = 1'b0;
      msr(1'b0, `OFS_CFG0, '0, 1'b0);
      chk(rd, 64'h0, "config after reset");
      give_verdict();
   end

   initial begin
      #100000;
      err_count++;
      give_verdict();
   end
endmodule : two_thread_event_counter_control_tb
`default_nettype wire
